/* design/mac_mul_pkg.sv */
// Operation
// [RULE_01] Signed multiply: sign-extend 32-bit product, shift left when product shift set
// [RULE_02] Signed multiply: limit flag held unless shift and saturation set, then 8000h squared
// [RULE_03] Signed multiply: extension flag only for shift, no saturation, 8000h squared
// [RULE_04] Every variant sets zero flag from the stored accumulator result
// [RULE_05] Signed and mixed variants copy result bit 39 into negative flag
// [RULE_06] Signed negate: shift, negate, clear limit and extension flags, never saturate
// [RULE_07] Mixed variants: first operand signed, second unsigned, product sign-extended
// [RULE_08] Rounded mixed: add 8000h, store, clear accumulator low word
// [RULE_09] Plain mixed stores product, mixed negate stores negated product, no rounding
// [RULE_10] Mixed variants hold limit and sticky overflow, clear extension, never saturate
// [RULE_11] Rounded unsigned: zero-extend product, add 8000h, store, clear low word
// [RULE_12] Rounded unsigned may saturate, sets limit on saturation, clears negative flag
// [RULE_13] Rounded unsigned sets extension flag when extension bits are in use
// [RULE_14] Form byte A3, 83 or 93; third byte C0 is signed multiply
// [RULE_15] Third byte C8 is signed negate multiply
// [RULE_16] Third byte 41 rounded mixed, 40 plain mixed, 48 mixed negate
// [RULE_17] Third byte 01 is rounded unsigned multiply
// [RULE_18] All clear overflow and carry; signed and unsigned hold sticky overflow
// [RULE_19] Signed multiply saturates only under the saturation mode flag
package mac_mul_pkg;
	localparam int OPW  = 16;
	localparam int ACCW = 40;
	localparam int PRDW = 32;
	localparam int SGNB = 31;
	// Instruction byte positions
	localparam int FORM_HI = 31;
	localparam int FORM_LO = 24;
	localparam int SUB_HI  = 15;
	localparam int SUB_LO  = 8;
	localparam logic [7:0] FORM_RR = 8'hA3;
	localparam logic [7:0] FORM_RI = 8'h83;
	localparam logic [7:0] FORM_XI = 8'h93;
	localparam logic [7:0] SUB_SMUL  = 8'hC0;
	localparam logic [7:0] SUB_SNEG  = 8'hC8;
	localparam logic [7:0] SUB_MRND  = 8'h41;
	localparam logic [7:0] SUB_MIX   = 8'h40;
	localparam logic [7:0] SUB_MNEG  = 8'h48;
	localparam logic [7:0] SUB_URND  = 8'h01;
	localparam logic [15:0] MIN_WORD = 16'h8000;
	localparam logic [39:0] RND_K    = 40'h00_0000_8000;
	localparam logic [39:0] SAT_POS  = 40'h00_7FFF_FFFF;
	// Register indices on the plain port
	localparam logic [2:0] RA_CTRL  = 3'h0;
	localparam logic [2:0] RA_FLAGS = 3'h1;
	localparam logic [2:0] RA_ACC0  = 3'h2;
	localparam logic [2:0] RA_ACC1  = 3'h3;
	localparam logic [2:0] RA_ACCX  = 3'h4;
	localparam logic [2:0] RA_LOW   = 3'h5;
	localparam logic [2:0] RA_STAT  = 3'h6;
	localparam logic [2:0] RA_MASK  = 3'h7;
	// Field positions
	localparam int C_SHIFT = 0;
	localparam int C_SAT   = 1;
	localparam int F_ZERO = 0;
	localparam int F_NEG  = 1;
	localparam int F_CRY  = 2;
	localparam int F_OVF  = 3;
	localparam int F_EXT  = 4;
	localparam int F_LIM  = 5;
	localparam int F_SOVF = 6;
	localparam int FLGW   = 7;
	localparam int E_DONE = 0;
	localparam int E_SAT  = 1;
	localparam int E_ILL  = 2;
	localparam int EVW    = 3;
	localparam logic [15:0] RST_WORD = 16'h0000;
	typedef enum logic [2:0] {
		OP_SMUL = 3'h0,
		OP_SNEG = 3'h1,
		OP_MRND = 3'h3,
		OP_MIX  = 3'h2,
		OP_MNEG = 3'h6,
		OP_URND = 3'h7
	} mul_op_t;
	// True when bits above the 32-bit signed range carry information
	function automatic logic ext_used(input logic [39:0] v);
		ext_used = !((&v[39:SGNB]) || !(|v[39:SGNB]));
	endfunction
endpackage

/* design/mul_if.sv */
`timescale 1ns/1ps
interface mul_if;
	mac_mul_pkg::mul_op_t op;
	logic                 legal;
	logic [15:0]          a;
	logic [15:0]          b;
	logic                 shift;
	logic                 satm;
	logic [39:0]          res;
	logic                 sat;
	logic                 ext;
	modport dec (output op, output legal);
	modport alu (input op, input a, input b, input shift, input satm,
		output res, output sat, output ext);
	modport core (input op, input legal, input res, input sat, input ext,
		output a, output b, output shift, output satm);
endinterface

/* design/mul_decode.sv */
`timescale 1ns/1ps
module mul_decode (
	input  wire logic [31:0] instr,
	mul_if.dec               d
);
	logic [7:0] form;
	logic [7:0] sub;
	logic       form_ok;

	// Byte 0 selects operand form, byte 2 selects the variant
	assign form = instr[mac_mul_pkg::FORM_HI:mac_mul_pkg::FORM_LO];
	assign sub  = instr[mac_mul_pkg::SUB_HI:mac_mul_pkg::SUB_LO];
	assign form_ok = (form == mac_mul_pkg::FORM_RR) || (form == mac_mul_pkg::FORM_RI) ||
		(form == mac_mul_pkg::FORM_XI); // RULE_14

	// Unknown variant codes fall out as not legal
	always_comb begin
		d.op    = mac_mul_pkg::OP_SMUL;
		d.legal = form_ok;
		case (sub)
			mac_mul_pkg::SUB_SMUL: d.op = mac_mul_pkg::OP_SMUL; // RULE_14
			mac_mul_pkg::SUB_SNEG: d.op = mac_mul_pkg::OP_SNEG; // RULE_15
			mac_mul_pkg::SUB_MRND: d.op = mac_mul_pkg::OP_MRND; // RULE_16
			mac_mul_pkg::SUB_MIX:  d.op = mac_mul_pkg::OP_MIX;  // RULE_16
			mac_mul_pkg::SUB_MNEG: d.op = mac_mul_pkg::OP_MNEG; // RULE_16
			mac_mul_pkg::SUB_URND: d.op = mac_mul_pkg::OP_URND; // RULE_17
			default:               d.legal = 1'b0;
		endcase
	end
endmodule

/* design/mul_alu.sv */
`timescale 1ns/1ps
module mul_alu (
	mul_if.alu u
);
	logic signed [31:0] p_ss;
	logic signed [32:0] p_su;
	logic        [31:0] p_uu;
	logic        [39:0] x_ss;
	logic        [39:0] x_su;
	logic        [39:0] x_uu;
	logic               both_min;

	// Three product flavours; a single shared multiplier would save area
	assign p_ss = $signed(u.a) * $signed(u.b);
	assign p_su = $signed(u.a) * $signed({1'b0, u.b}); // RULE_07
	assign p_uu = u.a * u.b;
	assign x_ss = {{8{p_ss[31]}}, p_ss};
	assign x_su = {{7{p_su[32]}}, p_su}; // RULE_07
	assign x_uu = {8'h00, p_uu} + mac_mul_pkg::RND_K; // RULE_11
	assign both_min = (u.a == mac_mul_pkg::MIN_WORD) && (u.b == mac_mul_pkg::MIN_WORD);

	// Result and side information per variant
	always_comb begin
		u.res = x_ss;
		u.sat = 1'b0;
		u.ext = 1'b0;
		case (u.op)
			mac_mul_pkg::OP_SMUL: begin
				u.res = u.shift ? {x_ss[38:0], 1'b0} : x_ss; // RULE_01
				u.ext = u.shift && !u.satm && both_min; // RULE_03
				if (u.shift && u.satm && both_min) begin
					u.res = mac_mul_pkg::SAT_POS; // RULE_19
					u.sat = 1'b1; // RULE_02
				end
			end
			mac_mul_pkg::OP_SNEG: begin
				u.res = u.shift ? {x_ss[38:0], 1'b0} : x_ss;
				u.res = 40'h00_0000_0000 - u.res; // RULE_06
			end
			mac_mul_pkg::OP_MRND: u.res = x_su + mac_mul_pkg::RND_K; // RULE_08
			mac_mul_pkg::OP_MIX:  u.res = x_su; // RULE_09
			mac_mul_pkg::OP_MNEG: u.res = 40'h00_0000_0000 - x_su; // RULE_09
			mac_mul_pkg::OP_URND: begin
				u.res = x_uu;
				if (u.satm && mac_mul_pkg::ext_used(x_uu)) begin
					u.res = mac_mul_pkg::SAT_POS; // RULE_12
					u.sat = 1'b1;
				end
				u.ext = mac_mul_pkg::ext_used(u.res); // RULE_13
			end
			default: u.res = x_ss;
		endcase
	end
endmodule

/* design/mac_multiply_group.sv */
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module mac_multiply_group (
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        instr_valid,
	input  wire logic [31:0] instr_word,
	input  wire logic [15:0] op1,
	input  wire logic [15:0] op2,
	input  wire logic [2:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	output logic      [39:0] accumulator,
	output logic      [15:0] accumulator_low_word,
	output logic             zero_flag,
	output logic             negative_flag,
	output logic             carry_flag,
	output logic             overflow_flag,
	output logic             extension_used_flag,
	output logic             sticky_limit_flag,
	output logic             sticky_overflow_flag,
	output logic             done,
	output logic             illegal,
	output logic             irq
);
	//--------------------------------------------------------------
	// Internal state
	//--------------------------------------------------------------
	logic [1:0]                     ctrl_r;
	logic [39:0]                    acc_r;
	logic [15:0]                    low_r;
	logic [mac_mul_pkg::FLGW-1:0]   flg_r;
	logic [mac_mul_pkg::FLGW-1:0]   flg_nxt;
	logic [mac_mul_pkg::EVW-1:0]    stat_r;
	logic [mac_mul_pkg::EVW-1:0]    mask_r;
	logic [mac_mul_pkg::EVW-1:0]    ev_nxt;
	logic [15:0]                    rdata_r;
	logic [15:0]                    rdata_nxt;
	logic                           done_r;
	logic                           ill_r;
	logic                           irq_r;
	logic                           go;
	logic                           bad;
	logic                           rnd_form;

	mul_if mi ();

	//--------------------------------------------------------------
	// Submodules
	//--------------------------------------------------------------
	mul_decode u_dec (
		.instr (instr_word),
		.d     (mi.dec)
	);

	mul_alu u_alu (
		.u (mi.alu)
	);

	// Operands come straight from the pipeline on the same clock
	assign mi.a     = op1;
	assign mi.b     = op2;
	assign mi.shift = ctrl_r[mac_mul_pkg::C_SHIFT];
	assign mi.satm  = ctrl_r[mac_mul_pkg::C_SAT];

	assign go  = instr_valid && mi.legal;
	assign bad = instr_valid && !mi.legal;
	assign rnd_form = (mi.op == mac_mul_pkg::OP_MRND) ||
		(mi.op == mac_mul_pkg::OP_URND);

	//--------------------------------------------------------------
	// Register access helpers
	//--------------------------------------------------------------
	function automatic logic wr_hit(
		input logic       wr,
		input logic [2:0] a,
		input logic [2:0] idx
	);
		wr_hit = wr && (a == idx);
	endfunction

	//--------------------------------------------------------------
	// Mode control
	//--------------------------------------------------------------
	// Software sets product shift and saturation mode
	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl_r <= 2'b00;
		end else if (wr_hit(reg_wr, reg_addr, mac_mul_pkg::RA_CTRL)) begin
			ctrl_r <= reg_wdata[1:0];
		end
	end

	//--------------------------------------------------------------
	// Accumulator
	//--------------------------------------------------------------
	// An instruction in the same cycle as a software write wins
	always_ff @(posedge mclk) begin
		if (srst) begin
			acc_r <= 40'h00_0000_0000;
		end else if (go) begin
			acc_r <= mi.res; // RULE_01
		end else if (wr_hit(reg_wr, reg_addr, mac_mul_pkg::RA_ACC0)) begin
			acc_r[15:0] <= reg_wdata;
		end else if (wr_hit(reg_wr, reg_addr, mac_mul_pkg::RA_ACC1)) begin
			acc_r[31:16] <= reg_wdata;
		end else if (wr_hit(reg_wr, reg_addr, mac_mul_pkg::RA_ACCX)) begin
			acc_r[39:32] <= reg_wdata[7:0];
		end
	end

	// Low word is cleared only by reset and by the rounding forms
	always_ff @(posedge mclk) begin
		if (srst) begin
			low_r <= mac_mul_pkg::RST_WORD;
		end else if (go && rnd_form) begin
			low_r <= mac_mul_pkg::RST_WORD; // RULE_08 RULE_11
		end else if (wr_hit(reg_wr, reg_addr, mac_mul_pkg::RA_LOW)) begin
			low_r <= reg_wdata;
		end
	end

	//--------------------------------------------------------------
	// Arithmetic flags
	//--------------------------------------------------------------
	// Next flag vector for the instruction being retired
	always_comb begin
		flg_nxt = flg_r;
		flg_nxt[mac_mul_pkg::F_OVF]  = 1'b0; // RULE_18
		flg_nxt[mac_mul_pkg::F_CRY]  = 1'b0; // RULE_18
		flg_nxt[mac_mul_pkg::F_ZERO] = (mi.res == 40'h00_0000_0000); // RULE_04
		flg_nxt[mac_mul_pkg::F_NEG]  = mi.res[mac_mul_pkg::ACCW-1]; // RULE_05
		flg_nxt[mac_mul_pkg::F_EXT]  = mi.ext;
		case (mi.op)
			mac_mul_pkg::OP_SMUL: begin
				if (mi.sat) begin
					flg_nxt[mac_mul_pkg::F_LIM] = 1'b1; // RULE_02
				end
			end
			mac_mul_pkg::OP_SNEG: begin
				flg_nxt[mac_mul_pkg::F_LIM] = 1'b0; // RULE_06
				flg_nxt[mac_mul_pkg::F_EXT] = 1'b0; // RULE_06
			end
			mac_mul_pkg::OP_URND: begin
				flg_nxt[mac_mul_pkg::F_NEG] = 1'b0; // RULE_12
				if (mi.sat) begin
					flg_nxt[mac_mul_pkg::F_LIM] = 1'b1; // RULE_12
				end
			end
			default: begin
				flg_nxt[mac_mul_pkg::F_EXT] = 1'b0; // RULE_10
			end
		endcase
	end

	// Sticky overflow is held by every instruction, changed only by reset and software
	always_ff @(posedge mclk) begin
		if (srst) begin
			flg_r <= '0;
		end else if (go) begin
			flg_r <= flg_nxt; // RULE_18 RULE_10
		end else if (wr_hit(reg_wr, reg_addr, mac_mul_pkg::RA_FLAGS)) begin
			flg_r <= reg_wdata[mac_mul_pkg::FLGW-1:0];
		end
	end

	//--------------------------------------------------------------
	// Events and interrupt
	//--------------------------------------------------------------
	// Events raised by this cycle's instruction
	always_comb begin
		ev_nxt = '0;
		ev_nxt[mac_mul_pkg::E_DONE] = go;
		ev_nxt[mac_mul_pkg::E_SAT]  = go && mi.sat;
		ev_nxt[mac_mul_pkg::E_ILL]  = bad;
	end

	// Write one to clear; a new event in the same cycle wins
	always_ff @(posedge mclk) begin
		if (srst) begin
			stat_r <= '0;
		end else if (wr_hit(reg_wr, reg_addr, mac_mul_pkg::RA_STAT)) begin
			stat_r <= (stat_r & ~reg_wdata[mac_mul_pkg::EVW-1:0]) | ev_nxt;
		end else begin
			stat_r <= stat_r | ev_nxt;
		end
	end

	// Mask gates events onto the interrupt line
	always_ff @(posedge mclk) begin
		if (srst) begin
			mask_r <= '0;
		end else if (wr_hit(reg_wr, reg_addr, mac_mul_pkg::RA_MASK)) begin
			mask_r <= reg_wdata[mac_mul_pkg::EVW-1:0];
		end
	end

	// Level output, lags the status bits by one cycle
	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(stat_r & mask_r);
		end
	end

	//--------------------------------------------------------------
	// Completion pulses
	//--------------------------------------------------------------
	// One-cycle pulses in the cycle the result is visible
	always_ff @(posedge mclk) begin
		if (srst) begin
			done_r <= 1'b0;
			ill_r  <= 1'b0;
		end else begin
			done_r <= go;
			ill_r  <= bad;
		end
	end

	//--------------------------------------------------------------
	// Read port
	//--------------------------------------------------------------
	// Read data selection, unused bits read as zero
	always_comb begin
		rdata_nxt = 16'h0000;
		case (reg_addr)
			mac_mul_pkg::RA_CTRL:  rdata_nxt[1:0] = ctrl_r;
			mac_mul_pkg::RA_FLAGS: rdata_nxt[mac_mul_pkg::FLGW-1:0] = flg_r;
			mac_mul_pkg::RA_ACC0:  rdata_nxt = acc_r[15:0];
			mac_mul_pkg::RA_ACC1:  rdata_nxt = acc_r[31:16];
			mac_mul_pkg::RA_ACCX:  rdata_nxt[7:0] = acc_r[39:32];
			mac_mul_pkg::RA_LOW:   rdata_nxt = low_r;
			mac_mul_pkg::RA_STAT:  rdata_nxt[mac_mul_pkg::EVW-1:0] = stat_r;
			mac_mul_pkg::RA_MASK:  rdata_nxt[mac_mul_pkg::EVW-1:0] = mask_r;
			default:               rdata_nxt = 16'h0000;
		endcase
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge mclk) begin
		if (srst) begin
			rdata_r <= 16'h0000;
		end else if (reg_rd) begin
			rdata_r <= rdata_nxt;
		end else begin
			rdata_r <= 16'h0000;
		end
	end

	//--------------------------------------------------------------
	// Outputs
	//--------------------------------------------------------------
	assign reg_rdata            = rdata_r;
	assign accumulator          = acc_r;
	assign accumulator_low_word = low_r;
	assign zero_flag            = flg_r[mac_mul_pkg::F_ZERO];
	assign negative_flag        = flg_r[mac_mul_pkg::F_NEG];
	assign carry_flag           = flg_r[mac_mul_pkg::F_CRY];
	assign overflow_flag        = flg_r[mac_mul_pkg::F_OVF];
	assign extension_used_flag  = flg_r[mac_mul_pkg::F_EXT];
	assign sticky_limit_flag    = flg_r[mac_mul_pkg::F_LIM];
	assign sticky_overflow_flag = flg_r[mac_mul_pkg::F_SOVF];
	assign done                 = done_r;
	assign illegal              = ill_r;
	assign irq                  = irq_r;
endmodule

/* testbench/mac_mul_properties.sv */
`timescale 1ns/1ps
module mac_mul_props (
	input wire logic        mclk,
	input wire logic        srst,
	input wire logic        instr_valid,
	input wire logic [31:0] instr_word,
	input wire logic [15:0] op1,
	input wire logic [15:0] op2,
	input wire logic [39:0] accumulator,
	input wire logic [15:0] accumulator_low_word,
	input wire logic        zero_flag,
	input wire logic        negative_flag,
	input wire logic        carry_flag,
	input wire logic        overflow_flag,
	input wire logic        extension_used_flag,
	input wire logic        sticky_limit_flag,
	input wire logic        sticky_overflow_flag,
	input wire logic        done,
	input wire logic        illegal
);
	// --------------
	// Issue decoding
	// --------------
	logic       f_ok;
	logic       m_ok;
	logic [7:0] sub;
	// Legality as the pipeline presents it; spare bytes play no part
	assign sub  = instr_word[15:8];
	assign f_ok = instr_word[31:24] inside {8'hA3, 8'h83, 8'h93};
	assign m_ok = sub inside {8'hC0, 8'hC8, 8'h41, 8'h40, 8'h48, 8'h01};
	default clocking @(posedge mclk);
	endclocking
	default disable iff (srst);
	chk_legal_answered: assert property (
		instr_valid && f_ok && m_ok |=> done && !illegal)
		else $error("legal issue not answered");
	chk_bad_refused: assert property (
		instr_valid && !(f_ok && m_ok) |=> illegal && !done && $stable(accumulator))
		else $error("bad issue not refused");
	chk_arith_cleared: assert property (
		done |-> !overflow_flag && !carry_flag)
		else $error("overflow or carry left set");
	chk_zero_follows: assert property (
		done |-> zero_flag == (accumulator == 40'h0))
		else $error("zero flag wrong");
	chk_neg_follows: assert property (
		done |-> negative_flag == (accumulator[39] && $past(sub) != 8'h01))
		else $error("negative flag wrong");
	chk_mixed_sticky: assert property (
		instr_valid && f_ok && sub inside {8'h40, 8'h41, 8'h48}
		|=> !extension_used_flag && $stable(sticky_limit_flag) && $stable(sticky_overflow_flag))
		else $error("mixed form touched sticky flags");
	chk_negate_clears: assert property (
		instr_valid && f_ok && sub == 8'hC8 |=> !sticky_limit_flag && !extension_used_flag)
		else $error("negate form kept limit or extension");
	chk_round_low: assert property (
		instr_valid && f_ok && sub inside {8'h41, 8'h01} |=> accumulator_low_word == 16'h0000)
		else $error("low word not cleared");
	chk_mixed_value: assert property (
		instr_valid && f_ok && sub == 8'h40
		|=> accumulator == $signed({{24{$past(op1[15])}}, $past(op1)}) * $signed({24'h0, $past(op2)}))
		else $error("mixed product wrong");
endmodule
bind mac_multiply_group mac_mul_props props (.*);

/* testbench/cpu_issue_model.sv */
`timescale 1ns/1ps
module cpu_issue_model (
	input  wire logic        mclk,
	output logic             instr_valid,
	output logic      [31:0] instr_word,
	output logic      [15:0] op1,
	output logic      [15:0] op2
);
	// Quiet issue slot from time zero
	initial begin
		instr_valid = 1'b0;
		instr_word  = 32'h0000_0000;
		op1         = 16'h0000;
		op2         = 16'h0000;
	end
	// One issue cycle; released lines show inverted data so stale values never pass
	task automatic issue(input logic [7:0] form, input logic [7:0] sub, input logic [15:0] a,
		input logic [15:0] b);
		@(posedge mclk);
		instr_valid <= 1'b1;
		instr_word  <= {form, 8'h00, sub, 8'h00};
		op1         <= a;
		op2         <= b;
		@(posedge mclk);
		instr_valid <= 1'b0;
		instr_word  <= ~{form, 8'h00, sub, 8'h00};
		op1         <= ~a;
		op2         <= ~b;
	endtask
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic        mclk;
	logic        srst;
	logic        reg_wr;
	logic        reg_rd;
	logic        instr_valid;
	logic        done;
	logic        illegal;
	logic        irq;
	logic        zero_flag;
	logic        negative_flag;
	logic        carry_flag;
	logic        overflow_flag;
	logic        extension_used_flag;
	logic        sticky_limit_flag;
	logic        sticky_overflow_flag;
	logic [2:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic [31:0] instr_word;
	logic [15:0] op1;
	logic [15:0] op2;
	logic [39:0] accumulator;
	logic [15:0] accumulator_low_word;
	logic [6:0]  flg;
	logic [62:0] last_e;
	int          fail_count;
	int          compares;
	mac_multiply_group dut (.*);
	cpu_issue_model cpu (.*);
	// Flags packed in register order
	assign flg = {sticky_overflow_flag, sticky_limit_flag, extension_used_flag, overflow_flag,
		carry_flag, negative_flag, zero_flag};
	// 200 MHz
	always #2.5 mclk = ~mclk;
	// -------------
	// Shared tasks
	// -------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// Expected {accumulator, low word, flags}; the low word is preset to 5A5A
	function automatic logic [62:0] model(input logic [7:0] s, input logic [15:0] a,
		input logic [15:0] b, input logic sh, input logic st, input logic p);
		logic signed [39:0] sa;
		logic [39:0] r;
		logic x;
		logic l;
		logic mn;
		sa = $signed(a);
		x  = 1'b0;
		l  = p;
		mn = (a == 16'h8000) && (b == 16'h8000);
		case (s)
			8'hC0, 8'hC8: begin
				r = sa * $signed(b);
				if (sh)
					r = r << 1;
				if (s == 8'hC8) begin
					r = -r;
					l = 1'b0;
				end else begin
					x = sh && !st && mn;
					if (sh && st && mn) begin
						r = mac_mul_pkg::SAT_POS;
						l = 1'b1;
					end
				end
			end
			8'h01: begin
				r = {24'h0, a} * {24'h0, b} + mac_mul_pkg::RND_K;
				if (st && r[39:31] != 9'h0) begin
					r = mac_mul_pkg::SAT_POS;
					l = 1'b1;
				end
				x = r[39:31] != 9'h0;
			end
			default: begin
				r = sa * $signed({24'h0, b});
				if (s == 8'h41)
					r = r + mac_mul_pkg::RND_K;
				if (s == 8'h48)
					r = -r;
			end
		endcase
		model = {r, (s == 8'h41 || s == 8'h01) ? 16'h0000 : 16'h5A5A, p, l, x, 2'b00,
			r[39] && s != 8'h01, r == 40'h0};
	endfunction
	// ---------
	// Scenarios
	// ---------
	// Every register and output starts cleared
	task automatic t_reset();
		logic [15:0] d;
		check(64'({done, illegal, irq}), 64'h0);
		check(64'({accumulator, accumulator_low_word, flg}), 64'h0);
		for (int i = 0; i < 8; i++) begin
			rd(3'(i), d);
			check(64'(d), 64'h0);
		end
		$display("reset test done");
	endtask
	// All variants, forms and control modes; sticky flags preset both ways
	task automatic t_ops();
		logic [7:0] sub [6] = '{8'hC0, 8'hC8, 8'h40, 8'h41, 8'h48, 8'h01};
		logic [7:0] frm [3] = '{8'hA3, 8'h83, 8'h93};
		logic [31:0] opd [4] = '{32'h8000_8000, 32'hFFFF_8000, 32'h1234_ABCD, 32'h0000_5555};
		logic p;
		for (int m = 0; m < 4; m++) begin
			for (int v = 0; v < 6; v++) begin
				for (int k = 0; k < 4; k++) begin
					p = ~(m[0] ^ k[0]) ^ v[0];
					wr(mac_mul_pkg::RA_CTRL, 16'(m));
					wr(mac_mul_pkg::RA_FLAGS, {9'h0, p, p, 5'h1C});
					wr(mac_mul_pkg::RA_LOW, 16'h5A5A);
					last_e = model(sub[v], opd[k][31:16], opd[k][15:0], m[0], m[1], p);
					cpu.issue(frm[(v + k + m) % 3], sub[v], opd[k][31:16], opd[k][15:0]);
					#1;
					check({done, accumulator, accumulator_low_word}, {1'b1, last_e[62:7]});
					check(64'(flg), 64'(last_e[6:0]));
				end
			end
		end
		check(64'(irq), 64'h0);
		$display("variant test done");
	endtask
	// Refused issues keep the accumulator and raise the masked event
	task automatic t_irq();
		logic [15:0] d0;
		logic [15:0] d1;
		logic [15:0] d2;
		// The variant sweep retired instructions and saturated at least once
		rd(mac_mul_pkg::RA_STAT, d0);
		check(64'(d0), 64'h3);
		wr(mac_mul_pkg::RA_STAT, 16'h0007);
		wr(mac_mul_pkg::RA_MASK, 16'h0004);
		cpu.issue(8'hB3, 8'hC0, 16'h1111, 16'h2222);
		#1;
		check({done, illegal}, 64'h1);
		@(posedge mclk);
		#1;
		check(64'(irq), 64'h1);
		cpu.issue(8'hA3, 8'hC1, 16'h1111, 16'h2222);
		rd(mac_mul_pkg::RA_ACC0, d0);
		rd(mac_mul_pkg::RA_ACC1, d1);
		rd(mac_mul_pkg::RA_ACCX, d2);
		check({d2, d1, d0}, 64'(last_e[62:23]));
		rd(mac_mul_pkg::RA_STAT, d0);
		check(64'(d0), 64'h4);
		wr(mac_mul_pkg::RA_STAT, 16'h0004);
		@(posedge mclk);
		#1;
		check(64'(irq), 64'h0);
		$display("refusal and interrupt test done");
	endtask
	task automatic final_report();
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Reset for ten cycles, then run the scenarios
	initial begin
		mclk       = 1'b0;
		srst       = 1'b1;
		reg_addr   = 3'h0;
		reg_wdata  = 16'h0000;
		reg_wr     = 1'b0;
		reg_rd     = 1'b0;
		fail_count = 0;
		compares   = 0;
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		#1;
		t_reset();
		t_ops();
		t_irq();
		final_report();
	end
endmodule
